// ---- hw/adc_decimation_filter.sv ----
// top: one-channel decimation filter with fast start and settling flag
`timescale 1ns/1ps
`default_nettype none

module adc_decimation_filter import adf_pkg::*; #(
    parameter int          FIFO_DEPTH = ADF_FIFO_DEPTH,
    parameter adf_settle_t SETTLE [8] = ADF_SETTLE
) (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 mod_bit,
    input  wire logic [ADF_SEL_W-1:0] decimation_ratio_sel,
    input  wire logic                 settle_restart,
    input  wire logic                 out_ready,
    output logic                      out_valid,
    output logic [ADF_WORD_W-1:0]     out_word,
    output logic                      sample_ready_strobe_n,
    output logic                      filter_settled,
    output logic                      fast_path_active,
    output logic                      buffer_ready
);

    // ---- modulator timing and configuration decode

    logic                 mod_phase;
    logic [ADF_SEL_W-1:0] sel_q;
    logic [ADF_CNT_W-1:0] phase_cnt;

    // one modulator bit every second clock [RULE3]
    wire tick = mod_phase;

    // a ratio change restarts decimation as a resync would [RULE11]
    wire restart = settle_restart || (decimation_ratio_sel != sel_q);

    // ratio decode [RULE2] [RULE17]
    wire [ADF_LOG2_W-1:0] ratio_log2 = adf_ratio_log2(decimation_ratio_sel);
    wire [ADF_LOG2_W-1:0] s3_log2    = adf_s3_log2(decimation_ratio_sel);
    wire [ADF_LOG2_W-1:0] casc_log2  = ratio_log2 - s3_log2;
    wire                  cascaded   = decimation_ratio_sel > ADF_SEL_S3MAX;
    wire [ADF_CNT_W-1:0]  ratio_mask = adf_mask(ratio_log2);
    wire [ADF_CNT_W-1:0]  s3_mask    = adf_mask(s3_log2);
    wire [ADF_CASC_W-1:0] casc_mask  = ADF_CASC_W'(adf_mask(casc_log2));

    // conversion ends every ratio bits [RULE1] [RULE4]
    wire conv_end = tick && (phase_cnt == ratio_mask);
    // sinc3 dumps every min(ratio, 1024) bits [RULE9]
    wire s3_dump  = tick && ((phase_cnt & s3_mask) == s3_mask);

    wire [ADF_CNT_W-1:0] next_phase_cnt =
        (restart || conv_end) ? '0 :
        tick                  ? phase_cnt + 1'b1 :
                                phase_cnt;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mod_phase <= 1'b0;
            sel_q     <= '0;
            phase_cnt <= '0;
        end else begin
            mod_phase <= ~mod_phase;
            sel_q     <= decimation_ratio_sel;
            phase_cnt <= next_phase_cnt;
        end
    end

    // ---- fast-settling sinc1 path over the full ratio [RULE6]

    logic [ADF_CNT_W:0] fast_sum;

    wire [ADF_CNT_W:0]    fast_total  = fast_sum + (ADF_CNT_W+1)'(mod_bit);
    wire [4:0]            fast_shift  = ADF_FAST_FS - {1'b0, ratio_log2};
    wire [ADF_WORD_W:0]   fast_scaled =
        (ADF_WORD_W+1)'({10'h000, fast_total} << fast_shift);
    wire [ADF_WORD_W-1:0] fast_word   = adf_to_signed(fast_scaled);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fast_sum <= '0;
        end else if (restart || conv_end) begin
            fast_sum <= '0;
        end else if (tick) begin
            fast_sum <= fast_total;
        end
    end

    // ---- sinc3 path, fed by the same bits in parallel [RULE5]

    logic                         s3_valid;
    logic signed [ADF_WORD_W-1:0] s3_word;

    adf_sinc3 #(
        .W         (ADF_CIC_W)
    ) u_sinc3 (
        .clk       (clk),
        .reset     (reset),
        .tick      (tick),
        .bit_in    (mod_bit),
        .clear     (restart),
        .dump      (s3_dump),
        .s3_log2   (s3_log2),
        .out_valid (s3_valid),
        .out_word  (s3_word)
    );

    // ---- cascaded sinc1 over 2..16 sinc3 words [RULE9] [RULE18]

    logic [ADF_CASC_W-1:0]       grp_cnt;
    logic signed [ADF_ACC_W-1:0] casc_acc;

    wire signed [ADF_ACC_W-1:0] casc_total = casc_acc + ADF_ACC_W'(s3_word);
    wire signed [ADF_ACC_W-1:0] casc_avg   = casc_total >>> casc_log2;
    wire [ADF_WORD_W-1:0]       casc_word  = casc_avg[ADF_WORD_W-1:0];
    wire                        casc_end   = s3_valid && (grp_cnt == casc_mask);

    // group restarts after each emitted average [RULE18]
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            grp_cnt  <= '0;
            casc_acc <= '0;
        end else if (restart || casc_end) begin
            grp_cnt  <= '0;
            casc_acc <= '0;
        end else if (s3_valid) begin
            grp_cnt  <= grp_cnt + 1'b1;
            casc_acc <= casc_total;
        end
    end

    // ---- output path selection

    adf_path_t path;
    adf_path_t next_path;
    logic [1:0] fast_cnt;
    logic       switch_q;

    // fast path for two conversions, then sinc3 until reset [RULE7]
    always_comb begin
        next_path = path;
        case (path)
            ADF_PATH_FAST: begin
                if (conv_end && (fast_cnt == ADF_FAST_CONVS - 2'h1)) begin
                    next_path = ADF_PATH_SINC3;
                end
            end
            ADF_PATH_SINC3: next_path = ADF_PATH_SINC3;
            default:        next_path = ADF_PATH_FAST;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            path     <= ADF_PATH_FAST;
            fast_cnt <= '0;
            switch_q <= 1'b0;
        end else begin
            path     <= next_path;
            switch_q <= (path == ADF_PATH_FAST) && (next_path != path);
            if (path==ADF_PATH_FAST && conv_end) fast_cnt <= fast_cnt + 1'b1;
        end
    end

    // the sinc3 word trailing the last fast word is the same conversion
    wire s3_emit = !switch_q && (cascaded ? casc_end : s3_valid); // [RULE8]
    wire emit    = (path == ADF_PATH_FAST) ? conv_end : s3_emit;
    wire [ADF_WORD_W-1:0] emit_word =
        (path == ADF_PATH_FAST) ? fast_word :
        cascaded                ? casc_word :
                                  s3_word;

    // ---- settling tracker: informs only, never gates words [RULE12]

    logic [ADF_SETTLE_W-1:0] settle_cnt;

    wire [ADF_SETTLE_W-1:0] settle_goal = SETTLE[decimation_ratio_sel];
    wire settle_step = tick && !filter_settled;
    wire settle_hit  = settle_step && (settle_cnt == settle_goal - 1'b1);

    // counts modulator periods from the last restart [RULE14] [RULE15]
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            settle_cnt     <= '0;
            filter_settled <= 1'b0;
        end else if (restart) begin
            settle_cnt     <= '0;
            filter_settled <= 1'b0;
        end else if (settle_step) begin
            settle_cnt     <= settle_cnt + 1'b1;
            filter_settled <= settle_hit;
        end
    end

    // ---- buffering toward the calibration stage

    adf_stream_if #(.W(ADF_WORD_W)) push_if ();
    adf_stream_if #(.W(ADF_WORD_W)) pop_if ();

    logic                  push_valid;
    logic [ADF_WORD_W-1:0] push_word;

    assign push_if.valid = push_valid;
    assign push_if.data  = push_word;

    // a held word is replaced by a newer one if the fifo stays full
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            push_valid <= 1'b0;
            push_word  <= '0;
        end else if (emit) begin
            push_valid <= 1'b1;
            push_word  <= emit_word;
        end else if (push_if.ready) begin
            push_valid <= 1'b0;
        end
    end

    adf_fifo #(
        .WIDTH (ADF_WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk   (clk),
        .reset (reset),
        .wr    (push_if),
        .rd    (pop_if)
    );

    wire out_free = !out_valid || out_ready;
    wire take     = pop_if.valid && out_free;

    assign pop_if.ready = out_free;

    // output register; strobe is low in the same cycle each new word appears on out_word, staying low for back-to-back words [RULE13]
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_valid             <= 1'b0;
            out_word              <= '0;
            sample_ready_strobe_n <= 1'b1;
        end else begin
            if (out_free) out_valid <= pop_if.valid;
            if (take)     out_word  <= pop_if.data;
            sample_ready_strobe_n <= ~take;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fast_path_active <= 1'b1;
            buffer_ready     <= 1'b0;
        end else begin
            fast_path_active <= (next_path == ADF_PATH_FAST);
            buffer_ready     <= push_if.ready;
        end
    end

    // ---- checks

    default clocking adf_cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_TICK_HALF_RATE: assert property ( // [RULE3]
        tick |=> !tick ##1 tick)
        else $error("modulator tick not at half clock rate");

    AST_DECIM_WRAP: assert property ( // [RULE1] [RULE4]
        conv_end && !restart |=> (phase_cnt == '0) && !tick)
        else $error("decimation counter did not wrap at ratio");

    AST_FAST_FIRST: assert property ( // [RULE6]
        (path == ADF_PATH_FAST) && conv_end
        |=> push_valid && (push_word == $past(fast_word)))
        else $error("fast path word not emitted at conversion end");

    AST_SWITCH_AFTER_TWO: assert property ( // [RULE7]
        $rose(path == ADF_PATH_SINC3) |-> fast_cnt == ADF_FAST_CONVS)
        else $error("path switched before two fast conversions");

    AST_SINC3_HOLDS: assert property ( // [RULE7]
        path == ADF_PATH_SINC3 |=> path == ADF_PATH_SINC3)
        else $error("sinc3 path left before reset");

    AST_DIRECT_S3: assert property ( // [RULE8]
        (path == ADF_PATH_SINC3) && !cascaded && s3_valid && !switch_q
        |=> push_valid && (push_word == $past(s3_word)))
        else $error("sinc3 word not passed straight through");

    AST_CASC_GROUP: assert property ( // [RULE9] [RULE18]
        (path == ADF_PATH_SINC3) && cascaded && casc_end && !switch_q
        && !restart |=> push_valid && (push_word == $past(casc_word))
        && (grp_cnt == '0))
        else $error("cascade average not emitted at group end");

    AST_SETTLE_CLEARS: assert property ( // [RULE11]
        restart |=> !filter_settled && (settle_cnt == '0))
        else $error("settling not restarted");

    AST_SETTLE_GOAL: assert property ( // [RULE14] [RULE15]
        $rose(filter_settled) |-> $past(settle_cnt) == settle_goal - 1'b1)
        else $error("settled flag at wrong period count");

    AST_NOT_GATED: assert property ( // [RULE12]
        (path == ADF_PATH_SINC3) && !cascaded && s3_valid && !switch_q
        && !filter_settled |=> push_valid)
        else $error("unsettled word was suppressed");

    AST_STROBE_WITH_WORD: assert property ( // [RULE13]
        !sample_ready_strobe_n |-> out_valid)
        else $error("strobe low without a word");

    COV_SWITCH:   cover property ($rose(path == ADF_PATH_SINC3));
    COV_CASCADE: cover property (cascaded && casc_end && path==ADF_PATH_SINC3);
    COV_SETTLED:  cover property ($rose(filter_settled));
    COV_BACKPRES: cover property (push_valid && !push_if.ready);

endmodule // adc_decimation_filter

`default_nettype wire

// ---- common/adf_pkg.sv ----
// package: constants, types and helpers of the decimation filter
// Summary of operation
// RULE1: filter averages modulator bits and decimates by the oversampling ratio
// RULE2: three-bit selector picks one of eight ratios, 128 through 16384
// RULE3: modulator bits arrive at half the main clock rate
// RULE4: output word rate equals modulator rate divided by the ratio
// RULE5: modulator stream feeds sinc3 path and fast path in parallel
// RULE6: after reset the output comes from the fast sinc1 path
// RULE7: after two fast conversions switch to sinc3 and stay until reset
// RULE8: ratios 128 to 1024 take the sinc3 result directly
// RULE9: ratios 2048 and up use sinc3 at 1024 then sinc1 by 2 to 16
// RULE10: nulls at multiples of output rate, response repeats at modulator rate
// RULE11: channel enable, input, gain change or resync restarts settling
// RULE12: unsettled words are not suppressed; reader discards them
// RULE13: reader trusts the first strobe falling edge after settling expires
// RULE14: settling 432, 816, 1584, 3120 modulator periods for 128 to 1024
// RULE15: settling 6192, 10288, 18480, 34864 periods for 2048 to 16384
// RULE16: sinc3 path is the cube of an N-long average over N
// RULE17: codes 0 to 7 map upward to ratios 128 to 16384
// RULE18: cascade sinc1 sums sinc3 words per group, emits average, restarts
package adf_pkg;

    localparam int ADF_SEL_W      = 3;
    localparam int ADF_WORD_W     = 24;
    localparam int ADF_CIC_W      = 32;
    localparam int ADF_CNT_W      = 14;
    localparam int ADF_LOG2_W     = 4;
    localparam int ADF_CASC_W     = 4;
    localparam int ADF_ACC_W      = 28;
    localparam int ADF_SETTLE_W   = 16;
    localparam int ADF_FIFO_DEPTH = 4;

    localparam logic [3:0] ADF_LOG2_MIN   = 4'h7;  // ratio 128
    localparam logic [3:0] ADF_LOG2_S3MAX = 4'hA;  // sinc3 caps at 1024
    localparam logic [2:0] ADF_SEL_S3MAX  = 3'h3;  // code of ratio 1024
    localparam logic [4:0] ADF_S3_BIAS    = 5'h15; // 3 * 7
    localparam logic [4:0] ADF_FAST_FS    = 5'h18; // 24 fraction bits
    localparam logic [1:0] ADF_FAST_CONVS = 2'h2;
    localparam logic [ADF_WORD_W-1:0] ADF_SIGN_FLIP = 24'h800000;
    localparam logic [ADF_WORD_W-1:0] ADF_WORD_MAX  = 24'hFFFFFF;

    typedef logic [ADF_SETTLE_W-1:0] adf_settle_t;

    // settling in modulator periods: 432 .. 34864
    localparam adf_settle_t ADF_SETTLE [8] = '{
        16'h01B0, 16'h0330, 16'h0630, 16'h0C30,
        16'h1830, 16'h2830, 16'h4830, 16'h8830
    };

    typedef enum logic {ADF_PATH_FAST, ADF_PATH_SINC3} adf_path_t;

    // code n selects ratio 2^(7+n)
    function automatic logic [3:0] adf_ratio_log2(input logic [2:0] sel);
        return ADF_LOG2_MIN + {1'b0, sel};
    endfunction

    function automatic logic [3:0] adf_s3_log2(input logic [2:0] sel);
        return (sel > ADF_SEL_S3MAX) ? ADF_LOG2_S3MAX : adf_ratio_log2(sel);
    endfunction

    function automatic logic [ADF_CNT_W-1:0] adf_mask(input logic [3:0] l2);
        return ADF_CNT_W'(({{ADF_CNT_W{1'b0}}, 1'b1} << l2) - 1'b1);
    endfunction

    // unsigned fraction of 2^24 to two's complement, full scale saturates
    function automatic logic [ADF_WORD_W-1:0] adf_to_signed(
        input logic [ADF_WORD_W:0] v);
        return (v[ADF_WORD_W] ? ADF_WORD_MAX : v[ADF_WORD_W-1:0])
               ^ ADF_SIGN_FLIP;
    endfunction

endpackage

// ---- common/adf_stream_if.sv ----
// interface: valid/ready word stream between filter modules
`timescale 1ns/1ps
`default_nettype none

interface adf_stream_if #(parameter int W = 24) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ---- hw/adf_fifo.sv ----
// module: small word FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module adf_fifo import adf_pkg::*; #(
    parameter int WIDTH = ADF_WORD_W,
    parameter int DEPTH = ADF_FIFO_DEPTH
) (
    input  wire logic  clk,
    input  wire logic  reset,
    adf_stream_if.snk  wr,
    adf_stream_if.src  rd
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wptr;
    logic [AW:0]      rptr;

    // depth must be a power of two: the extra pointer bit tells full
    wire full  = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
    wire empty = (wptr == rptr);
    wire push  = wr.valid && !full;
    wire pop   = rd.ready && !empty;

    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data  = mem[rptr[AW-1:0]];

    // pointers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            if (push) wptr <= wptr + 1'b1;
            if (pop)  rptr <= rptr + 1'b1;
        end
    end

    // storage needs no reset
    always_ff @(posedge clk) begin
        if (push) mem[wptr[AW-1:0]] <= wr.data;
    end

    AST_FIFO_FULL_HOLDS: assert property ( // [RULE12]
        @(posedge clk) disable iff (reset) full && !pop |=> full)
        else $error("fifo lost full state without a pop");

endmodule // adf_fifo

`default_nettype wire

// ---- hw/adf_sinc3.sv ----
// module: third-order sinc decimator with scaling to signed words
`timescale 1ns/1ps
`default_nettype none

module adf_sinc3 import adf_pkg::*; #(
    parameter int W = ADF_CIC_W
) (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  tick,
    input  wire logic                  bit_in,
    input  wire logic                  clear,
    input  wire logic                  dump,
    input  wire logic [ADF_LOG2_W-1:0] s3_log2,
    output logic                       out_valid,
    output logic [ADF_WORD_W-1:0]      out_word
);
    logic [W-1:0] integ [3];
    logic [W-1:0] dly   [3];
    logic [W-1:0] feed  [3];
    logic [W-1:0] comb  [3];
    logic [W-1:0] dly_d [3];

    // integrators at modulator rate, combs at decimated rate [RULE16]
    // comb delays give nulls at every output-rate multiple [RULE10]
    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_stage
            if (i == 0) begin : g_first
                assign feed[i]  = W'(bit_in);
                assign comb[i]  = integ[2] - dly[i];
                assign dly_d[i] = integ[2];
            end else begin : g_rest
                assign feed[i]  = integ[i-1];
                assign comb[i]  = comb[i-1] - dly[i];
                assign dly_d[i] = comb[i-1];
            end
        end
    endgenerate

    // wrap-around arithmetic is exact as long as W >= 3*log2(N)+1
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int k = 0; k < 3; k++) begin
                integ[k] <= '0;
                dly[k]   <= '0;
            end
        end else if (clear) begin
            for (int k = 0; k < 3; k++) begin
                integ[k] <= '0;
                dly[k]   <= '0;
            end
        end else begin
            for (int k = 0; k < 3; k++) begin
                if (tick) integ[k] <= integ[k] + feed[k];
                if (dump) dly[k]   <= dly_d[k];
            end
        end
    end

    // divide by N^3: result is a fraction of 2^24 [RULE16]
    wire [4:0]   shift  = 5'({1'b0, s3_log2} * 5'h03) - ADF_S3_BIAS;
    wire [W+2:0] ext    = {comb[2], 3'b000};
    wire [W+2:0] scaled = ext >> shift;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_valid <= 1'b0;
            out_word  <= '0;
        end else begin
            out_valid <= dump && !clear;
            if (dump) out_word <= adf_to_signed(scaled[ADF_WORD_W:0]);
        end
    end

    AST_S3_ONE_WORD_PER_DUMP: assert property ( // [RULE16]
        @(posedge clk) disable iff (reset)
        (dump && !clear |=> out_valid) and (!dump |=> !out_valid))
        else $error("sinc3 word not tied to its dump");

endmodule // adf_sinc3

`default_nettype wire

// ---- test/adf_partner.sv ----
// partner: modulator bit source and downstream reader of filter words
`timescale 1ns/1ps
`default_nettype none

module adf_partner (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [1:0] src_mode,
    input  wire logic [1:0] sink_mode,
    input  wire logic       sample_ready_strobe_n,
    input  wire logic       filter_settled,
    output logic            mod_bit,
    output logic            out_ready,
    output logic            word_trusted
);
    logic [31:0] rng;
    logic [1:0]  phase;

    // xorshift keeps the random stream repeatable from a fixed seed
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    // alternating bits change every other clock so the half-rate
    // sampling of the filter sees 0,1,0,1 whatever its phase
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rng       <= 32'h0000B23E;
            phase     <= 2'h0;
            mod_bit   <= 1'b0;
            out_ready <= 1'b1;
        end else begin
            rng   <= xorshift(rng);
            phase <= phase + 2'h1;
            case (src_mode)
                2'h0:    mod_bit <= 1'b0;
                2'h1:    mod_bit <= 1'b1;
                2'h2:    mod_bit <= phase[1];
                default: mod_bit <= rng[0];
            endcase
            case (sink_mode)
                2'h0:    out_ready <= 1'b1;
                2'h1:    out_ready <= 1'b0;
                default: out_ready <= rng[7];
            endcase
        end
    end

    // reader keeps only words shown once settling has run out; earlier
    // words are dropped because the filter does not hold them back
    assign word_trusted = filter_settled
                          & ~sample_ready_strobe_n;

endmodule // adf_partner
`default_nettype wire

// ---- test/adc_decimation_filter_tb_top.sv ----
// testbench: decimation filter against modulator source and word reader
`timescale 1ns/1ps
`default_nettype none

module adc_decimation_filter_tb_top import adf_pkg::*;;
    logic                  clk;
    logic                  reset;
    logic                  mod_bit;
    logic [ADF_SEL_W-1:0]  decimation_ratio_sel;
    logic                  settle_restart;
    logic                  out_ready;
    logic                  out_valid;
    logic [ADF_WORD_W-1:0] out_word;
    logic                  sample_ready_strobe_n;
    logic                  filter_settled;
    logic                  fast_path_active;
    logic                  buffer_ready;
    logic                  word_trusted;
    logic [1:0]            src_mode;
    logic [1:0]            sink_mode;
    logic                  held = 1'b0;
    logic [ADF_WORD_W-1:0] held_word;
    int                    n_errors = 0;
    int                    n_compared = 0;
    int                    cyc = 0;
    int                    n_strobe = 0;
    int                    n_taken = 0;
    int                    t_a;
    int                    t_b;
    int                    t0;
    // settling in modulator periods for codes 0..7
    localparam int SETTLE_TICKS [8] = '{16'h01B0, 16'h0330, 16'h0630,
        16'h0C30, 16'h1830, 16'h2830, 16'h4830, 16'h8830};

    adc_decimation_filter adc_decimation_filter_i (
        .clk(clk), .reset(reset), .mod_bit(mod_bit),
        .decimation_ratio_sel(decimation_ratio_sel),
        .settle_restart(settle_restart), .out_ready(out_ready),
        .out_valid(out_valid), .out_word(out_word),
        .sample_ready_strobe_n(sample_ready_strobe_n),
        .filter_settled(filter_settled),
        .fast_path_active(fast_path_active), .buffer_ready(buffer_ready));

    adf_partner adf_partner_i (
        .clk(clk), .reset(reset), .src_mode(src_mode),
        .sink_mode(sink_mode),
        .sample_ready_strobe_n(sample_ready_strobe_n),
        .filter_settled(filter_settled), .mod_bit(mod_bit),
        .out_ready(out_ready), .word_trusted(word_trusted));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic int exp_gap(input int c);
        return 2 << (7 + c);
    endfunction

    // zeros, ones, alternating bits map to bottom, top and mid scale
    function automatic logic [23:0] exp_word(input int m);
        case (m)
            0:       return 24'h800000;
            1:       return 24'h7FFFFF;
            default: return 24'h000000;
        endcase
    endfunction

    task automatic wrap_up();
        if (n_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk_word(input string w, input logic [23:0] e,
                            input logic [23:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic chk_flag(input string w, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %b seen %b", w, e, g);
        end
    endtask

    task automatic chk_count(input string w, input int lo, input int hi,
                             input int g);
        n_compared++;
        if (g < lo || g > hi) begin
            n_errors++;
            $display("mismatch %s expected %0d..%0d seen %0d", w, lo, hi, g);
        end
    endtask

    // next strobe low, sampled mid-cycle where outputs have settled
    task automatic wait_word(output int t);
        @(negedge clk);
        while (sample_ready_strobe_n !== 1'b0 && cyc < 99000)
            @(negedge clk);
        t = cyc;
    endtask

    task automatic restart(input logic [2:0] code, input logic [1:0] m);
        @(posedge clk);
        decimation_ratio_sel <= code;
        src_mode             <= m;
        settle_restart       <= 1'b1;
        @(posedge clk);
        settle_restart <= 1'b0;
    endtask

    // cycle count with a ceiling well above the planned run
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 99000) begin
            n_errors++;
            wrap_up();
        end
    end

    // a word refused under random stalls must stand unchanged
    always @(negedge clk) begin
        if (!reset && held) begin
            chk_flag("valid stands", 1'b1, out_valid);
            chk_word("word stands", held_word, out_word);
        end
        held      = sink_mode == 2'h2 && out_valid === 1'b1
                    && out_ready === 1'b0;
        held_word = out_word;
        if (sample_ready_strobe_n === 1'b0)
            n_strobe++;
        if (out_valid === 1'b1 && out_ready === 1'b1)
            n_taken++;
    end

    initial begin
        reset                = 1'b1;
        decimation_ratio_sel = 3'h0;
        settle_restart       = 1'b0;
        src_mode             = 2'h1;
        sink_mode            = 2'h0;
        repeat (4) @(posedge clk);
        chk_flag("fast_path_active", 1'b1, fast_path_active);
        chk_flag("filter_settled", 1'b0, filter_settled);
        reset <= 1'b0;
        wait_word(t_a);
        chk_word("fast word", 24'h7FFFFF, out_word);
        chk_flag("fast path on", 1'b1, fast_path_active);
        wait_word(t_b);
        chk_count("fast gap", 256, 256, t_b - t_a);
        repeat (4) @(negedge clk);
        chk_flag("fast path off", 1'b0, fast_path_active);
        // every short code: settling time, trusted word value, spacing
        for (int c = 0; c < 6; c++) begin
            restart(3'(c), 2'(c % 3));
            t0 = cyc;
            @(negedge clk);
            chk_flag("settle cleared", 1'b0, filter_settled);
            chk_flag("stays sinc3", 1'b0, fast_path_active);
            do @(negedge clk);
            while (filter_settled !== 1'b1 && cyc - t0 < 80000);
            chk_count("settle", 2 * SETTLE_TICKS[c] - 4,
                2 * SETTLE_TICKS[c] + 4, cyc - t0);
            wait_word(t_a);
            chk_flag("trusted", 1'b1, word_trusted);
            chk_word("word a", exp_word(c % 3), out_word);
            wait_word(t_b);
            chk_word("word b", exp_word(c % 3), out_word);
            chk_count("gap", exp_gap(c), exp_gap(c),
                t_b - t_a);
        end
        // fill the buffer with the reader stalled, then drain it
        restart(3'h0, 2'h3);
        sink_mode <= 2'h1;
        repeat (2600) @(negedge clk);
        chk_flag("buffer_ready", 1'b0, buffer_ready);
        chk_flag("valid waits", 1'b1, out_valid);
        t_a = n_taken;
        @(posedge clk);
        sink_mode <= 2'h0;
        repeat (200) @(negedge clk);
        chk_count("drained", ADF_FIFO_DEPTH, ADF_FIFO_DEPTH + 2,
            n_taken - t_a);
        chk_flag("buffer free", 1'b1, buffer_ready);
        @(posedge clk);
        sink_mode <= 2'h2;
        repeat (3000) @(negedge clk);
        // long codes give no word within a short ratio's time
        for (int c = 6; c < 8; c++) begin
            restart(3'(c), 2'h3);
            t_a = n_strobe;
            repeat (4000) @(negedge clk);
            chk_count("no early word", 0, 0, n_strobe - t_a);
        end
        wrap_up();
    end

endmodule // adc_decimation_filter_tb_top
`default_nettype wire
